// *** rtl/psfc_port_select_caps.sv ***
`timescale 1ns/1ps
module psfc_port_select_caps (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_n,
    input  wire logic [6:0]         dev_id,
    input  wire logic               pclk,
    input  wire logic [1:0]         rx_lock,
    input  wire logic [1:0]         bcc_caps_valid,
    input  wire logic [7:0]         bcc_caps_p0,
    input  wire logic [7:0]         bcc_caps_p1,
    input  wire logic [1:0]         fsc_upper_p0,
    input  wire logic [1:0]         fsc_upper_p1,
    output logic [7:0]              far_caps_p0,
    output logic [7:0]              far_caps_p1,
    output psfc_pkg::psfc_fsc_mode_e fast_side_channel_mode_p0,
    output psfc_pkg::psfc_fsc_mode_e fast_side_channel_mode_p1,
    output logic [1:0]              far_dual_lane_capable,
    output logic                    secondary_address_enable
);
    logic [6:0] dev_id_s1, dev_id_s2;
    logic [1:0] lock_s1, lock_s2;
    logic       pclk_s1, pclk_s2, pclk_s3, pclk_edge;
    logic [7:0] port_sel_reg, tally_reg, window_left_reg, rd_data, reg_ptr, wr_data;
    logic [7:0] caps_reg [2];
    logic [7:0] bcc_caps [2];
    logic [6:0] osc_acc_reg, osc_sum;
    logic       counting_reg, osc_tick, acc_sec, wr_stb;
    logic [1:0] cap_load, cap_wr;

    // write steering for one port copy
    function automatic logic port_hit(input logic p, input logic sec, input logic [7:0] sel);
        if (sec) begin
            return p;
        end else if (sel[psfc_pkg::SEL_SEC_EN_BIT]) begin
            return ~p;
        end
        return p ? sel[psfc_pkg::SEL_P1_BIT] : sel[psfc_pkg::SEL_P0_BIT];
    endfunction

    function automatic psfc_pkg::psfc_fsc_mode_e fsc_mode(input logic [1:0] up, input logic lsb);
        return psfc_pkg::psfc_fsc_mode_e'({up, lsb});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    psfc_i2c_target u_i2c (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe_n (sda_oe_n),
        .dev_id   (dev_id_s2),
        .sec_en   (secondary_address_enable),
        .rd_data  (rd_data),
        .reg_ptr  (reg_ptr),
        .acc_sec  (acc_sec),
        .wr_stb   (wr_stb),
        .wr_data  (wr_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dev_id_s1 <= 7'h00;
            dev_id_s2 <= 7'h00;
            lock_s1   <= 2'h0;
            lock_s2   <= 2'h0;
            pclk_s1   <= 1'b0;
            pclk_s2   <= 1'b0;
            pclk_s3   <= 1'b0;
        end else begin
            dev_id_s1 <= dev_id;
            dev_id_s2 <= dev_id_s1;
            lock_s1   <= rx_lock;
            lock_s2   <= lock_s1;
            pclk_s1   <= pclk;
            pclk_s2   <= pclk_s1;
            pclk_s3   <= pclk_s2;
        end
    end

    // edge seen only after the second stage, so metastability stays in stage one
    assign pclk_edge = pclk_s2 & ~pclk_s3;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_sel_reg <= psfc_pkg::PORT_SEL_RESET;
        end else if (wr_stb && reg_ptr == psfc_pkg::ADDR_PORT_SEL) begin
            port_sel_reg <= wr_data & psfc_pkg::PORT_SEL_MASK;
        end
    end

    assign secondary_address_enable = port_sel_reg[psfc_pkg::SEL_SEC_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // oscillator period is not a whole number of clk periods, so an ns
    // accumulator keeps the window exact on average rather than rounding
    assign osc_sum  = osc_acc_reg + 7'(psfc_pkg::CLK_PERIOD_NS);
    assign osc_tick = osc_sum >= 7'(psfc_pkg::OSC_PERIOD_NS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tally_reg       <= psfc_pkg::EDGE_CNT_RESET;
            window_left_reg <= 8'h00;
            counting_reg    <= 1'b0;
            osc_acc_reg     <= 7'h00;
        end else if (wr_stb && reg_ptr == psfc_pkg::ADDR_EDGE_CNT) begin
            tally_reg       <= psfc_pkg::EDGE_CNT_RESET;
            window_left_reg <= wr_data;
            counting_reg    <= wr_data != 8'h00;
            osc_acc_reg     <= 7'h00;
        end else if (counting_reg) begin
            osc_acc_reg <= osc_tick ? osc_sum - 7'(psfc_pkg::OSC_PERIOD_NS) : osc_sum;
            if (osc_tick) begin
                window_left_reg <= window_left_reg - 8'h01;
                if (window_left_reg == 8'h01) begin
                    counting_reg <= 1'b0;
                end
            end
            if (pclk_edge && tally_reg != psfc_pkg::TALLY_MAX) begin
                tally_reg <= tally_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign bcc_caps[0] = bcc_caps_p0;
    assign bcc_caps[1] = bcc_caps_p1;

    for (genvar p = 0; p < 2; p++) begin : g_caps
        assign cap_wr[p]   = wr_stb && reg_ptr == psfc_pkg::ADDR_CAPS_A &&
                             port_hit(1'(p), acc_sec, port_sel_reg);
        assign cap_load[p] = bcc_caps_valid[p] & lock_s2[p] &
                             ~caps_reg[p][psfc_pkg::CAP_FREEZE_BIT];

        // a software write in the same cycle as an auto-load wins
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                caps_reg[p] <= psfc_pkg::CAPS_RESET;
            end else if (cap_wr[p]) begin
                caps_reg[p] <= wr_data & psfc_pkg::CAPS_WRITE_MASK;
            end else if (cap_load[p]) begin
                caps_reg[p] <= bcc_caps[p] & psfc_pkg::CAPS_LOAD_MASK;
            end
        end

        assign far_dual_lane_capable[p] = caps_reg[p][psfc_pkg::CAP_DUAL_BIT];
    end

    assign far_caps_p0 = caps_reg[0];
    assign far_caps_p1 = caps_reg[1];
    assign fast_side_channel_mode_p0 =
        fsc_mode(fsc_upper_p0, caps_reg[0][psfc_pkg::CAP_FSC_LSB_BIT]);
    assign fast_side_channel_mode_p1 =
        fsc_mode(fsc_upper_p1, caps_reg[1][psfc_pkg::CAP_FSC_LSB_BIT]);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_data = psfc_pkg::READ_ZERO;
        unique case (reg_ptr)
            psfc_pkg::ADDR_PORT_SEL: rd_data = port_sel_reg;
            psfc_pkg::ADDR_EDGE_CNT: rd_data = tally_reg;
            psfc_pkg::ADDR_CAPS_A: begin
                if (acc_sec || (!secondary_address_enable &&
                                port_sel_reg[psfc_pkg::SEL_P1_BIT])) begin
                    rd_data = caps_reg[1];
                end else begin
                    rd_data = caps_reg[0];
                end
            end
            default: rd_data = psfc_pkg::READ_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_short_window;
        counting_reg [*2] ##1 !counting_reg;
    endsequence

    property p_sec_writes_port1;
        @(posedge clk) disable iff (!rst_n)
        wr_stb && acc_sec && reg_ptr == psfc_pkg::ADDR_CAPS_A
        |=> caps_reg[1] == ($past(wr_data) & psfc_pkg::CAPS_WRITE_MASK) &&
            ($stable(caps_reg[0]) || $past(cap_load[0]));
    endproperty
    a_sec_writes_port1: assert property (p_sec_writes_port1)
        else $error("secondary address write did not reach port 1 only");

    property p_sel1_read;
        @(posedge clk) disable iff (!rst_n)
        !acc_sec && !secondary_address_enable && port_sel_reg[psfc_pkg::SEL_P1_BIT] &&
        reg_ptr == psfc_pkg::ADDR_CAPS_A |-> rd_data == caps_reg[1];
    endproperty
    a_sel1_read: assert property (p_sel1_read)
        else $error("second port select read did not return port 1 copy");

    property p_sec_ignores_sel;
        @(posedge clk) disable iff (!rst_n)
        wr_stb && !acc_sec && secondary_address_enable && !cap_load[1]
        |=> $stable(caps_reg[1]);
    endproperty
    a_sec_ignores_sel: assert property (p_sec_ignores_sel)
        else $error("primary write reached port 1 while secondary enabled");

    property p_sel0_reset;
        @(posedge clk) $rose(rst_n) |-> port_sel_reg == psfc_pkg::PORT_SEL_RESET;
    endproperty
    a_sel0_reset: assert property (p_sel0_reset)
        else $error("port select did not reset to first port");

    property p_sel1_write;
        @(posedge clk) disable iff (!rst_n)
        cap_wr[1] && !acc_sec |-> port_sel_reg[psfc_pkg::SEL_P1_BIT] &&
                                  !secondary_address_enable;
    endproperty
    a_sel1_write: assert property (p_sel1_write)
        else $error("port 1 copy written without second port select");

    property p_window_one;
        @(posedge clk) disable iff (!rst_n)
        wr_stb && reg_ptr == psfc_pkg::ADDR_EDGE_CNT && wr_data == 8'h01
        ##1 !wr_stb [*2] |-> counting_reg ##1 !counting_reg or s_short_window;
    endproperty
    a_window_one: assert property (p_window_one)
        else $error("one-period window did not close in time");

    property p_saturate;
        @(posedge clk) disable iff (!rst_n)
        tally_reg == psfc_pkg::TALLY_MAX && !wr_stb |=> tally_reg == psfc_pkg::TALLY_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("edge tally wrapped past maximum");

    property p_freeze;
        @(posedge clk) disable iff (!rst_n)
        caps_reg[0][psfc_pkg::CAP_FREEZE_BIT] && !cap_wr[0] |=> $stable(caps_reg[0]);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen capabilities changed");

    property p_autoload;
        @(posedge clk) disable iff (!rst_n)
        cap_load[0] && !cap_wr[0]
        |=> caps_reg[0] == ($past(bcc_caps_p0) & psfc_pkg::CAPS_LOAD_MASK);
    endproperty
    a_autoload: assert property (p_autoload)
        else $error("capabilities not loaded from back channel");

endmodule

// *** rtl/psfc_pkg.sv ***
package psfc_pkg;

    localparam logic [7:0] ADDR_PORT_SEL    = 8'h1E;
    localparam logic [7:0] ADDR_EDGE_CNT    = 8'h1F;
    localparam logic [7:0] ADDR_CAPS_A      = 8'h20;

    localparam logic [7:0] PORT_SEL_RESET   = 8'h01;
    localparam logic [7:0] PORT_SEL_MASK    = 8'h07;
    localparam logic [7:0] EDGE_CNT_RESET   = 8'h00;
    localparam logic [7:0] CAPS_RESET       = 8'h00;
    localparam logic [7:0] CAPS_WRITE_MASK  = 8'hCF;
    localparam logic [7:0] CAPS_LOAD_MASK   = 8'h4F;
    localparam logic [7:0] TALLY_MAX        = 8'hFF;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    localparam int         SEL_SEC_EN_BIT   = 2;
    localparam int         SEL_P1_BIT       = 1;
    localparam int         SEL_P0_BIT       = 0;
    localparam int         CAP_FREEZE_BIT   = 7;
    localparam int         CAP_FSC_LSB_BIT  = 6;
    localparam int         CAP_DUAL_BIT     = 3;

    localparam logic [6:0] SEC_ADDR_STEP    = 7'h01;
    localparam logic [3:0] I2C_BYTE_BITS    = 4'h8;

    localparam int         OSC_PERIOD_NS    = 40;
    localparam int         CLK_PERIOD_NS    = 25;

    typedef enum logic [2:0] {
        FSC_NORMAL  = 3'b000,
        FSC_GPIO1   = 3'b001,
        FSC_GPIO2   = 3'b010,
        FSC_GPIO4   = 3'b011,
        FSC_SPI_FWD = 3'b110,
        FSC_SPI_REV = 3'b111
    } psfc_fsc_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_HACK = 3'b100,
        ST_NEXT = 3'b101
    } psfc_i2c_state_e;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'b00,
        KIND_PTR  = 2'b01,
        KIND_DATA = 2'b10
    } psfc_byte_kind_e;

endpackage

// *** rtl/psfc_i2c_target.sv ***
`timescale 1ns/1ps
module psfc_i2c_target (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    input  wire logic [6:0] dev_id,
    input  wire logic       sec_en,
    input  wire logic [7:0] rd_data,
    output logic [7:0]      reg_ptr,
    output logic            acc_sec,
    output logic            wr_stb,
    output logic [7:0]      wr_data
);
    logic                       scl_s1, scl_s2, scl_s3;
    logic                       sda_s1, sda_s2, sda_s3;
    logic                       scl_rise, scl_fall, bus_start, bus_stop;
    psfc_pkg::psfc_i2c_state_e  state_reg;
    psfc_pkg::psfc_byte_kind_e  kind_reg;
    logic [3:0]                 bit_cnt_reg;
    logic [7:0]                 shift_reg;
    logic                       is_read_reg, drive_reg, inc_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
        end
    end

    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    // open drain: only ever pull low
    assign sda_o     = 1'b0;
    assign sda_oe_n  = ~drive_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg   <= psfc_pkg::ST_IDLE;
            kind_reg    <= psfc_pkg::KIND_ADDR;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            is_read_reg <= 1'b0;
            drive_reg   <= 1'b0;
            inc_reg     <= 1'b0;
            reg_ptr     <= 8'h00;
            acc_sec     <= 1'b0;
            wr_stb      <= 1'b0;
            wr_data     <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                state_reg   <= psfc_pkg::ST_RX;
                kind_reg    <= psfc_pkg::KIND_ADDR;
                bit_cnt_reg <= 4'h0;
                drive_reg   <= 1'b0;
            end else if (bus_stop) begin
                state_reg <= psfc_pkg::ST_IDLE;
                drive_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    psfc_pkg::ST_IDLE: begin
                    end
                    psfc_pkg::ST_RX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_s2};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == psfc_pkg::I2C_BYTE_BITS) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= psfc_pkg::ST_ACK;
                            drive_reg   <= 1'b1;
                            inc_reg     <= 1'b0;
                            unique case (kind_reg)
                                psfc_pkg::KIND_ADDR: begin
                                    is_read_reg <= shift_reg[0];
                                    kind_reg    <= psfc_pkg::KIND_PTR;
                                    if (shift_reg[7:1] == dev_id) begin
                                        acc_sec <= 1'b0;
                                    end else if (sec_en &&
                                        shift_reg[7:1] == dev_id + psfc_pkg::SEC_ADDR_STEP) begin
                                        acc_sec <= 1'b1;
                                    end else begin
                                        state_reg <= psfc_pkg::ST_IDLE;
                                        drive_reg <= 1'b0;
                                    end
                                end
                                psfc_pkg::KIND_PTR: begin
                                    reg_ptr  <= shift_reg;
                                    kind_reg <= psfc_pkg::KIND_DATA;
                                end
                                default: begin
                                    wr_stb  <= 1'b1;
                                    wr_data <= shift_reg;
                                    inc_reg <= 1'b1;
                                end
                            endcase
                        end
                    end
                    psfc_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            if (inc_reg) begin
                                reg_ptr <= reg_ptr + 8'h01;
                            end
                            if (is_read_reg) begin
                                state_reg   <= psfc_pkg::ST_TX;
                                shift_reg   <= rd_data;
                                drive_reg   <= ~rd_data[7];
                                bit_cnt_reg <= 4'h1;
                            end else begin
                                state_reg <= psfc_pkg::ST_RX;
                                drive_reg <= 1'b0;
                            end
                        end
                    end
                    psfc_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == psfc_pkg::I2C_BYTE_BITS) begin
                                drive_reg <= 1'b0;
                                state_reg <= psfc_pkg::ST_HACK;
                            end else begin
                                shift_reg   <= {shift_reg[6:0], 1'b0};
                                drive_reg   <= ~shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    psfc_pkg::ST_HACK: begin
                        if (scl_rise) begin
                            if (sda_s2) begin
                                state_reg <= psfc_pkg::ST_IDLE;
                            end else begin
                                reg_ptr   <= reg_ptr + 8'h01;
                                state_reg <= psfc_pkg::ST_NEXT;
                            end
                        end
                    end
                    psfc_pkg::ST_NEXT: begin
                        if (scl_fall) begin
                            state_reg   <= psfc_pkg::ST_TX;
                            shift_reg   <= rd_data;
                            drive_reg   <= ~rd_data[7];
                            bit_cnt_reg <= 4'h1;
                        end
                    end
                    default: begin
                        state_reg <= psfc_pkg::ST_IDLE;
                        drive_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// *** tb/psfc_i2c_host.sv ***
`timescale 1ns/1ps
module psfc_i2c_host (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // sda_drv 1 releases the line, the pull-up then gives high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // 25 clk a phase: well above the 4 clk the target's sync chain needs
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        tick(12);
        sda_drv <= b;
        tick(13);
        scl <= 1'b1;
        tick(12);
        r = sda_line;
        tick(13);
    endtask
    // s=1 start or repeated start, s=0 stop
    task automatic cond(input logic s);
        logic r;
        bit_io(s, r);
        sda_drv <= ~s;
        tick(25);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ha, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ha, ack);
    endtask
endmodule

// *** tb/tb_psfc_port_select_caps.sv ***
`timescale 1ns/1ps
module tb_psfc_port_select_caps;
    localparam int PCLK_NS = 200;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       pclk = 1'b0;
    logic       scl, sda_drv, sda_o, sda_oe_n, sec;
    logic [6:0] dev_id;
    logic [1:0] rx_lock = 2'h0, vld = 2'h0, up0 = 2'h0, up1 = 2'h0, dual;
    logic [7:0] b0 = 8'h00, b1 = 8'h00, v, w, cp0, cp1;
    logic [7:0] a_sel = psfc_pkg::ADDR_PORT_SEL, a_cnt = psfc_pkg::ADDR_EDGE_CNT;
    logic [7:0] a_cap = psfc_pkg::ADDR_CAPS_A, lmask = psfc_pkg::CAPS_LOAD_MASK;
    logic [7:0] nv[4] = '{8'h00, 8'h01, 8'h7D, 8'hFF};
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    psfc_pkg::psfc_fsc_mode_e m0, m1;
    int         fails = 0, checks = 0, seed = 32'h79c54a42;
    wire        sda_line = sda_drv & (sda_oe_n | sda_o);
    psfc_port_select_caps psfc_port_select_caps_inst (.clk(clk), .rst_n(rst_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .dev_id(dev_id), .pclk(pclk),
        .rx_lock(rx_lock), .bcc_caps_valid(vld), .bcc_caps_p0(b0), .bcc_caps_p1(b1),
        .fsc_upper_p0(up0), .fsc_upper_p1(up1), .far_caps_p0(cp0), .far_caps_p1(cp1),
        .fast_side_channel_mode_p0(m0), .fast_side_channel_mode_p1(m1),
        .far_dual_lane_capable(dual), .secondary_address_enable(sec));
    psfc_i2c_host psfc_i2c_host_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // free-running pixel clock of 8 clk periods, offset so its rising edges fall 0.5 ns before a clk rising edge
    initial begin
        #37;
        forever #(PCLK_NS / 2) pclk = ~pclk;
    end
    function automatic logic [7:0] ecap(input logic [7:0] x);
        return x & psfc_pkg::CAPS_WRITE_MASK;
    endfunction
    function automatic logic [7:0] edges(input logic [7:0] n);
        return 8'(int'(n) * psfc_pkg::OSC_PERIOD_NS / PCLK_NS);
    endfunction
    // tol allows one edge either way: pclk is sampled through a sync chain
    task automatic chk(input logic [7:0] got, exp, input logic tol = 1'b0);
        checks++;
        if (got !== exp && !(tol && (got === exp + 8'h01 || got === exp - 8'h01))) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, d, input logic [6:0] ao = 7'h00,
                      input logic ok = 1'b1);
        logic [7:0] x;
        logic k;
        psfc_i2c_host_inst.cond(1'b1);
        psfc_i2c_host_inst.byte_io({dev_id + ao, 1'b0}, 1'b1, x, k);
        chk({7'h00, k}, {7'h00, ~ok});
        psfc_i2c_host_inst.byte_io(p, 1'b1, x, k);
        psfc_i2c_host_inst.byte_io(d, 1'b1, x, k);
        psfc_i2c_host_inst.cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] p, e, input logic tol = 1'b0);
        logic [7:0] x;
        logic k;
        psfc_i2c_host_inst.cond(1'b1);
        psfc_i2c_host_inst.byte_io({dev_id, 1'b0}, 1'b1, x, k);
        psfc_i2c_host_inst.byte_io(p, 1'b1, x, k);
        psfc_i2c_host_inst.cond(1'b1);
        psfc_i2c_host_inst.byte_io({dev_id, 1'b1}, 1'b1, x, k);
        psfc_i2c_host_inst.byte_io(8'hFF, 1'b1, x, k);
        psfc_i2c_host_inst.cond(1'b0);
        chk(x, e, tol);
    endtask
    task automatic pulse(input logic [1:0] p);
        @(posedge clk);
        vld <= p;
        @(posedge clk);
        vld <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // traffic needs about 1.2 ms; 2 ms means a hang
    initial begin
        #2000000;
        fails++;
        summarize();
    end
    initial begin
        dev_id = {2'b01, 5'($random(seed))};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rx_lock <= 2'h3;
        rd(a_sel, psfc_pkg::PORT_SEL_RESET);
        rd(a_cap, psfc_pkg::CAPS_RESET);
        rd(8'h21, psfc_pkg::READ_ZERO);
        wr(a_sel, 8'hFB);
        rd(a_sel, 8'h03);
        v = 8'($random(seed));
        up0 <= 2'($random(seed));
        wr(a_cap, v);
        chk(cp0, ecap(v));
        chk(cp1, ecap(v));
        chk(8'(m0), {5'h00, up0, v[6]});
        chk({7'h00, dual[0]}, {7'h00, v[3]});
        wr(a_sel, 8'h02);
        w = 8'($random(seed));
        wr(a_cap, w);
        chk(cp0, ecap(v));
        rd(a_cap, ecap(w));
        wr(a_sel, 8'h03);
        rd(a_cap, ecap(w));
        wr(a_sel, 8'h01);
        rd(a_cap, ecap(v));
        wr(a_sel, 8'h03);
        wr(a_cap, 8'h00);
        foreach (codes[i]) begin
            b0 <= {1'b1, codes[i][0], 6'($random(seed))};
            b1 <= 8'($random(seed));
            up0 <= codes[i][2:1];
            up1 <= 2'($random(seed));
            pulse(2'h3);
            chk(cp0, b0 & lmask);
            chk(8'(m0), {5'h00, codes[i]});
            chk(cp1, b1 & lmask);
            chk(8'(m1), {5'h00, up1, b1[6]});
            chk({7'h00, dual[1]}, {7'h00, b1[3]});
        end
        wr(a_sel, 8'h01);
        v = 8'($random(seed)) | 8'h80;
        wr(a_cap, v);
        b0 <= ~v;
        pulse(2'h3);
        chk(cp0, ecap(v));
        w = b1;
        b1 <= ~w;
        rx_lock <= 2'h0;
        repeat (4) @(posedge clk);
        pulse(2'h2);
        chk(cp1, w & lmask);
        wr(a_sel, 8'h06);
        chk({7'h00, sec}, 8'h01);
        wr(a_cap, w, 7'h01);
        chk(cp1, ecap(w));
        wr(a_cap, ~w);
        chk(cp0, ecap(~w));
        chk(cp1, ecap(w));
        wr(a_cap, 8'h00, 7'h02, 1'b0);
        foreach (nv[i]) begin
            wr(a_cnt, nv[i]);
            rd(a_cnt, edges(nv[i]), 1'b1);
        end
        summarize();
    end
endmodule
